/* uart_line_modem_status.sv */
// Purpose: line status, modem status and scratch registers of a console uart
// Assumes: receiver and transmitter datapath report events as one-cycle pulses
// Notes:   serial and modem inputs are taken as synchronous to clk_sys_in
`timescale 1ns/1ps
`include "uart_status_consts.svh"

// Behaviour
// - set framing error flag, bit 3, when a character lacks a stop bit
// - reading line status clears overrun, parity and framing error flags
// - set break flag, bit 4, when input stays low over a character time
// - a break loads exactly one all-zero character into the receiver
// - reading line status clears the break flag
// - set holding-empty, bit 5, when holding moves to shift with nothing new
// - raise holding-empty interrupt when flag sets and its enable is on
// - transmitter empty, bit 6, only while holding and shift are both empty
// - receive fifo error bit 7 is not implemented
// - delta flags for clear-to-send, set-ready, carrier on change since read
// - ring change flag, bit 2, on any ring input change since read
// - modem bits 7:4 show inverted current levels of the four inputs
// - 8-bit read/write scratch register at offset 0x1c, no effect
// - modem status register sits at offset 0x18
// - data ready, bit 0, while a character waits; cleared on buffer read
// - overrun, bit 1, when a new character arrives before the old was read
// - parity error, bit 2, only when parity is enabled
module uart_line_modem_status #(
  parameter int unsigned BIT_CYCLES_MAX = 16'hffff
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         srst_in,
  input  wire logic [7:0]                   reg_addr_in,
  input  wire logic                         reg_rd_in,
  input  wire logic                         reg_wr_in,
  input  wire uart_status_pkg::word_t       reg_wdata_in,
  output      uart_status_pkg::word_t       reg_rdata_out,
  input  wire logic                         serial_in,
  input  wire logic [15:0]                  bit_cycles_in,
  input  wire logic [1:0]                   data_bits_sel_in,
  input  wire logic                         two_stop_in,
  input  wire logic                         parity_on_in,
  input  wire logic                         rx_char_done_in,
  input  wire logic                         rx_stop_bad_in,
  input  wire logic                         rx_parity_bad_in,
  input  wire logic                         rx_buffer_read_in,
  input  wire logic                         tx_holding_write_in,
  input  wire logic                         tx_move_to_shift_in,
  input  wire logic                         tx_shift_done_in,
  input  wire logic                         tx_empty_irq_en_in,
  input  wire logic                         clear_to_send_in_n,
  input  wire logic                         set_ready_in_n,
  input  wire logic                         ring_in_n,
  input  wire logic                         carrier_in_n,
  output      logic                         rx_load_zero_out,
  output      logic                         tx_empty_irq_out
);
  import uart_status_pkg::*;

  // bit periods that a low line must outlast before it counts as a break
  function automatic logic [4:0] char_bits(input logic [1:0] dsel, input logic par, input logic two);
    char_bits = `BREAK_BASE_BITS + {3'h0, dsel} + {4'h0, par} + {4'h0, two};
  endfunction : char_bits

  // one address compare, shared by the read strobes, the write and the read mux
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    addr_is = (addr == offset);
  endfunction : addr_is

  logic       line_stat_rd;
  logic       modem_stat_rd;
  logic       scratch_rd;
  logic       scratch_wr;
  assign line_stat_rd  = reg_rd_in && addr_is(reg_addr_in, `LINE_STAT_OFFSET);
  assign modem_stat_rd = reg_rd_in && addr_is(reg_addr_in, `MODEM_STAT_OFFSET);
  assign scratch_rd    = reg_rd_in && addr_is(reg_addr_in, `SCRATCH_OFFSET);
  assign scratch_wr    = reg_wr_in && addr_is(reg_addr_in, `SCRATCH_OFFSET);

  // receive side flags
  logic       rx_char_waiting_r,  rx_char_waiting_nxt;
  logic       overrun_flag_r,     overrun_flag_nxt;
  logic       parity_err_flag_r,  parity_err_flag_nxt;
  logic       framing_err_flag_r, framing_err_flag_nxt;
  logic       break_seen_flag_r,  break_seen_flag_nxt;
  logic       brk_char;
  logic       rx_arrival;

  // a break character takes the same path as a received one
  assign rx_arrival = rx_char_done_in || brk_char;

  always_comb begin
    rx_char_waiting_nxt  = rx_char_waiting_r;
    overrun_flag_nxt     = overrun_flag_r;
    parity_err_flag_nxt  = parity_err_flag_r;
    framing_err_flag_nxt = framing_err_flag_r;
    break_seen_flag_nxt  = break_seen_flag_r;
    // clears first so an event in the read cycle still sets: no error is lost
    if (line_stat_rd) begin
      overrun_flag_nxt     = 1'b0;
      parity_err_flag_nxt  = 1'b0;
      framing_err_flag_nxt = 1'b0;
      break_seen_flag_nxt  = 1'b0;
    end
    if (rx_buffer_read_in) begin
      rx_char_waiting_nxt = 1'b0;
    end
    if (rx_arrival) begin
      if (rx_char_waiting_r && !rx_buffer_read_in) begin
        overrun_flag_nxt = 1'b1;
      end
      rx_char_waiting_nxt = 1'b1;
      if (rx_stop_bad_in || brk_char) begin
        framing_err_flag_nxt = 1'b1;
      end
      if (rx_parity_bad_in && parity_on_in) begin
        parity_err_flag_nxt = 1'b1;
      end
    end
    if (brk_char) begin
      break_seen_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rx_char_waiting_r  <= 1'b0;
      overrun_flag_r     <= 1'b0;
      parity_err_flag_r  <= 1'b0;
      framing_err_flag_r <= 1'b0;
      break_seen_flag_r  <= 1'b0;
    end else begin
      rx_char_waiting_r  <= rx_char_waiting_nxt;
      overrun_flag_r     <= overrun_flag_nxt;
      parity_err_flag_r  <= parity_err_flag_nxt;
      framing_err_flag_r <= framing_err_flag_nxt;
      break_seen_flag_r  <= break_seen_flag_nxt;
    end
  end

  // transmit side flags
  logic       tx_holding_empty_r, tx_holding_empty_nxt;
  logic       shift_busy_r,       shift_busy_nxt;
  logic       tx_all_empty;
  logic       irq_r,              irq_nxt;

  always_comb begin
    tx_holding_empty_nxt = tx_holding_empty_r;
    shift_busy_nxt       = shift_busy_r;
    // a write in the move cycle means new data waits, so the flag stays low
    if (tx_holding_write_in) begin
      tx_holding_empty_nxt = 1'b0;
    end else if (tx_move_to_shift_in) begin
      tx_holding_empty_nxt = 1'b1;
    end
    if (tx_move_to_shift_in) begin
      shift_busy_nxt = 1'b1;
    end else if (tx_shift_done_in) begin
      shift_busy_nxt = 1'b0;
    end
    // rising edge only: a flag that stays set does not interrupt again
    irq_nxt = !tx_holding_empty_r && tx_holding_empty_nxt && tx_empty_irq_en_in;
  end
  assign tx_all_empty = tx_holding_empty_r && !shift_busy_r;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_holding_empty_r <= `HOLD_EMPTY_RESET;
      shift_busy_r       <= 1'b0;
      irq_r              <= 1'b0;
    end else begin
      tx_holding_empty_r <= tx_holding_empty_nxt;
      shift_busy_r       <= shift_busy_nxt;
      irq_r              <= irq_nxt;
    end
  end
  assign tx_empty_irq_out = irq_r;

  // break detector: counts low time in bit periods
  brk_state_e  brk_r,  brk_nxt;
  logic [15:0] cyc_r,  cyc_nxt;
  logic [4:0]  bits_r, bits_nxt;

  always_comb begin
    brk_nxt  = brk_r;
    cyc_nxt  = cyc_r;
    bits_nxt = bits_r;
    brk_char = 1'b0;
    case (brk_r)
      BRK_IDLE: begin
        cyc_nxt  = 16'h0000;
        bits_nxt = 5'h00;
        if (!serial_in) begin
          brk_nxt = BRK_COUNT;
        end
      end
      BRK_COUNT: begin
        if (serial_in) begin
          brk_nxt = BRK_IDLE;
        end else if (cyc_r >= bit_cycles_in - 16'h0001) begin
          cyc_nxt  = 16'h0000;
          bits_nxt = bits_r + 5'h01;
          // low past the whole character, not merely equal to it
          if (bits_r == char_bits(data_bits_sel_in, parity_on_in, two_stop_in)) begin
            brk_char = 1'b1;
            brk_nxt  = BRK_HELD;
          end
        end else begin
          cyc_nxt = cyc_r + 16'h0001;
        end
      end
      BRK_HELD: begin
        // one zero character only, however long the line stays low
        if (serial_in) begin
          brk_nxt = BRK_IDLE;
        end
      end
      default: begin
        brk_nxt = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      brk_r  <= BRK_IDLE;
      cyc_r  <= 16'h0000;
      bits_r <= 5'h00;
    end else begin
      brk_r  <= brk_nxt;
      cyc_r  <= cyc_nxt;
      bits_r <= bits_nxt;
    end
  end
  assign rx_load_zero_out = brk_char;

  // modem status: one alike cell per input; levels lag the pins by a cycle
  logic [3:0]      modem_now;
  wire logic [3:0] modem_seen;
  wire logic [3:0] delta_seen;
  assign modem_now = {~carrier_in_n, ~ring_in_n, ~set_ready_in_n, ~clear_to_send_in_n};

  for (genvar i = 0; i < 4; i++) begin : g_modem
    logic level_r,  level_nxt;
    logic change_r, change_nxt;

    always_comb begin
      level_nxt  = modem_now[i];
      // a change in the read cycle survives the clear, so no edge goes unreported
      change_nxt = (change_r && !modem_stat_rd) || (modem_now[i] ^ level_r);
    end

    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        level_r  <= 1'b0;
        change_r <= 1'b0;
      end else begin
        level_r  <= level_nxt;
        change_r <= change_nxt;
      end
    end
    assign modem_seen[i] = level_r;
    assign delta_seen[i] = change_r;
  end

  // scratch: software storage only, drives nothing else
  byte_t scratch_r, scratch_nxt;
  always_comb begin
    scratch_nxt = scratch_r;
    if (scratch_wr) begin
      scratch_nxt = reg_wdata_in[7:0];
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      scratch_r <= `SCRATCH_RESET;
    end else begin
      scratch_r <= scratch_nxt;
    end
  end

  // read data registered: one cycle after the read strobe, zero otherwise
  word_t rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (line_stat_rd) begin
      rdata_nxt[`LINE_WAITING_BIT]    = rx_char_waiting_r;
      rdata_nxt[`LINE_OVERRUN_BIT]    = overrun_flag_r;
      rdata_nxt[`LINE_PARITY_BIT]     = parity_err_flag_r;
      rdata_nxt[`LINE_FRAMING_BIT]    = framing_err_flag_r;
      rdata_nxt[`LINE_BREAK_BIT]      = break_seen_flag_r;
      rdata_nxt[`LINE_HOLD_EMPTY_BIT] = tx_holding_empty_r;
      rdata_nxt[`LINE_ALL_EMPTY_BIT]  = tx_all_empty;
    end else if (modem_stat_rd) begin
      rdata_nxt[`MODEM_DELTA_LSB +: 4] = delta_seen;
      rdata_nxt[`MODEM_STATE_LSB +: 4] = modem_seen;
    end else if (scratch_rd) begin
      rdata_nxt[7:0] = scratch_r;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata_out = rdata_r;

endmodule : uart_line_modem_status

/* uart_status_consts.svh */
// Purpose: offsets, field positions and timing counts of the uart status block
// Assumes: 32-bit register words, byte offsets
// Notes:   definitions only
`ifndef UART_STATUS_CONSTS_SVH
`define UART_STATUS_CONSTS_SVH

`define LINE_STAT_OFFSET    8'h14
`define MODEM_STAT_OFFSET   8'h18
`define SCRATCH_OFFSET      8'h1c

`define LINE_WAITING_BIT    0
`define LINE_OVERRUN_BIT    1
`define LINE_PARITY_BIT     2
`define LINE_FRAMING_BIT    3
`define LINE_BREAK_BIT      4
`define LINE_HOLD_EMPTY_BIT 5
`define LINE_ALL_EMPTY_BIT  6

`define MODEM_DELTA_LSB     0
`define MODEM_STATE_LSB     4

`define SCRATCH_RESET       8'h00
`define HOLD_EMPTY_RESET    1'b1
`define LCR_RESET           8'h03

`define BREAK_BASE_BITS     5'h06

`endif

/* uart_status_pkg.sv */
// Purpose: types shared by the uart status block
// Assumes: nothing
// Notes:   timing lives in the consts header
package uart_status_pkg;
  typedef enum logic [1:0] {
    BRK_IDLE,
    BRK_COUNT,
    BRK_HELD
  } brk_state_e;
  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;
endpackage : uart_status_pkg

/* uart_status_checker.sv */
// Purpose: port assertions of the uart status block
// Assumes: one clock, sync reset
// Notes:   bound to the top module
`timescale 1ns/1ps
module uart_status_checker (
  input wire logic                   clk_sys_in,
  input wire logic                   srst_in,
  input wire logic [7:0]             reg_addr_in,
  input wire logic                   reg_rd_in,
  input wire logic                   reg_wr_in,
  input wire uart_status_pkg::word_t reg_wdata_in,
  input wire uart_status_pkg::word_t reg_rdata_out,
  input wire logic                   rx_char_done_in,
  input wire logic                   rx_stop_bad_in,
  input wire logic                   tx_move_to_shift_in,
  input wire logic                   tx_holding_write_in,
  input wire logic                   ring_in_n,
  input wire logic                   rx_load_zero_out,
  input wire logic                   tx_empty_irq_out
);
  import uart_status_pkg::*;
  logic       rl;
  logic       rm;
  logic [7:0] wlo;
  assign rl  = reg_rd_in && reg_addr_in == 8'h14;
  assign rm  = reg_rd_in && reg_addr_in == 8'h18;
  assign wlo = reg_wdata_in[7:0];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == '0) else $error("rdata not idle");
  resv_zero_a: assert property (($past(rl) ? reg_rdata_out[31:7] : reg_rdata_out[31:8]) == '0)
    else $error("reserved bits set");
  framing_set_a: assert property ((rx_char_done_in && rx_stop_bad_in) ##1 !rl ##1 rl |=> reg_rdata_out[3])
    else $error("framing flag missing");
  rd_clear_a: assert property ((rl && !rx_char_done_in && !rx_load_zero_out)[*2] |=> reg_rdata_out[4:1] == '0)
    else $error("flags not cleared");
  hold_empty_a: assert property ((tx_move_to_shift_in && !tx_holding_write_in) ##1
    (!rl && !tx_holding_write_in) ##1 rl |=> reg_rdata_out[5])
    else $error("holding empty missing");
  all_empty_a: assert property ($past(rl) && reg_rdata_out[6] |-> reg_rdata_out[5]) else $error("empty w/o holding");
  irq_pulse_a: assert property (tx_empty_irq_out |-> $past(tx_move_to_shift_in) ##1 !tx_empty_irq_out)
    else $error("irq without cause");
  ring_delta_a: assert property ($changed(ring_in_n) ##1 (!reg_rd_in)[*4] ##1 rm |=> reg_rdata_out[2])
    else $error("ring delta missing");
  brk_once_a: assert property (rx_load_zero_out |=> !rx_load_zero_out) else $error("zero load repeated");
  scr_rw_a: assert property (reg_wr_in && reg_addr_in == 8'h1c ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 8'h1c
    |=> reg_rdata_out[7:0] == $past(wlo, 2)) else $error("scratch mismatch");
  brk_c: cover property (rx_load_zero_out);
  irq_c: cover property (tx_empty_irq_out);
  delta_c: cover property (rm ##1 reg_rdata_out[2]);
endmodule : uart_status_checker
bind uart_line_modem_status uart_status_checker u_chk (.clk_sys_in, .srst_in, .reg_addr_in, .reg_rd_in,
  .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .rx_char_done_in, .rx_stop_bad_in, .tx_move_to_shift_in,
  .tx_holding_write_in, .ring_in_n, .rx_load_zero_out, .tx_empty_irq_out);

/* far_end_model.sv */
// Purpose: remote terminal: serial line and modem lines
// Assumes: changes at falling edges
// Notes:   line idles high, modem lines idle inactive high
`timescale 1ns/1ps
module far_end_model (
  input  wire logic clk_in,
  output logic       serial_out,
  output logic [3:0] modem_n_out
);
  initial {serial_out, modem_n_out} = 5'h1f;
  // break of any length; no character framing needed here
  task automatic hold_low(input int n);
    @(negedge clk_in);
    serial_out = 1'h0;
    repeat (n) @(negedge clk_in);
    serial_out = 1'h1;
  endtask : hold_low
  task automatic set_modem(input logic [3:0] v);
    @(negedge clk_in);
    modem_n_out = v;
  endtask : set_modem
endmodule : far_end_model

/* test_uart_line_modem_status.sv */
// Purpose: self-checking bench of the uart status block
// Assumes: reads answer one cycle later
// Notes:   expected reads queued by the driver
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_uart_line_modem_status;
  import uart_status_pkg::*;
  logic        clk_sys_in = 1'h0, srst_in = 1'h1, rd = 1'h0, wr = 1'h0, rd_d = 1'h0;
  logic        po = 1'h0, tw = 1'h0, ie = 1'h1, ser, lz, irq;
  logic [6:0]  ev = 7'h00;
  logic [7:0]  addr = 8'h00, lf = 8'h4a;
  logic [1:0]  ds = 2'h3;
  logic [3:0]  mn;
  logic [15:0] bc = 16'h0002;
  word_t       wd = '0, rdata, ex, exp_q[$];
  int          n_mismatch = 0, cmp_count = 0, nz = 0, nirq = 0, ch;
  always #20 clk_sys_in = ~clk_sys_in;
  far_end_model u_far (.clk_in(clk_sys_in), .serial_out(ser), .modem_n_out(mn));
  uart_line_modem_status u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdata), .serial_in(ser),
    .bit_cycles_in(bc), .data_bits_sel_in(ds), .two_stop_in(tw), .parity_on_in(po),
    .rx_char_done_in(ev[0]), .rx_stop_bad_in(ev[1]), .rx_parity_bad_in(ev[2]), .rx_buffer_read_in(ev[3]),
    .tx_holding_write_in(ev[4]), .tx_move_to_shift_in(ev[5]), .tx_shift_done_in(ev[6]),
    .tx_empty_irq_en_in(ie), .clear_to_send_in_n(mn[0]), .set_ready_in_n(mn[1]), .ring_in_n(mn[2]),
    .carrier_in_n(mn[3]), .rx_load_zero_out(lz), .tx_empty_irq_out(irq));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic rdq(input logic [7:0] a, input word_t e);
    @(negedge clk_sys_in);
    {rd, wr, addr} = {2'h2, a};
    exp_q.push_back(e);
  endtask : rdq
  task automatic wrt(input logic [7:0] a, input word_t d);
    @(negedge clk_sys_in);
    {rd, wr, addr, wd} = {2'h1, a, d};
  endtask : wrt
  // drops strobes first, so no read overlaps an event pulse
  task automatic pulse(input logic [6:0] v);
    @(negedge clk_sys_in);
    {rd, wr, ev} = {2'h0, v};
    @(negedge clk_sys_in);
    ev = 7'h00;
  endtask : pulse
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  always @(posedge clk_sys_in) begin
    rd_d <= rd;
    nz   <= nz + int'(lz);
    nirq <= nirq + int'(irq);
  end
  always @(negedge clk_sys_in) if (rd_d) begin
    ex = exp_q.pop_front();
    `CHK("read data", ex, rdata)
  end
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in) srst_in = 1'h0;
    rdq(8'h14, 32'h0000_0060);
    rdq(8'h18, 32'h0000_0000);
    rdq(8'h20, 32'h0000_0000);
    wrt(8'h14, 32'hffff_ffff);
    rdq(8'h14, 32'h0000_0060);
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      wrt(8'h1c, {24'hff_ffff, lf});
      rdq(8'h1c, {24'h00_0000, lf});
    end
    pulse(7'h03);
    rdq(8'h14, 32'h0000_0069);
    rdq(8'h14, 32'h0000_0061);
    pulse(7'h08);
    rdq(8'h14, 32'h0000_0060);
    pulse(7'h01);
    po = 1'h1;
    pulse(7'h05);
    rdq(8'h14, 32'h0000_0067);
    pulse(7'h08);
    po = 1'h0;
    pulse(7'h05);
    rdq(8'h14, 32'h0000_0061);
    pulse(7'h08);
    pulse(7'h10);
    rdq(8'h14, 32'h0000_0000);
    pulse(7'h20);
    rdq(8'h14, 32'h0000_0020);
    pulse(7'h40);
    rdq(8'h14, 32'h0000_0060);
    ie = 1'h0;
    pulse(7'h10);
    pulse(7'h20);
    pulse(7'h40);
    `CHK("irq count", 1, nirq)
    for (int i = 0; i < 4; i++) begin
      pulse(7'h00);
      u_far.set_modem(4'hf ^ (4'h1 << i));
      pulse(7'h00);
      rdq(8'h18, 32'h0000_0011 << i);
      pulse(7'h00);
      u_far.set_modem(4'hf);
      pulse(7'h00);
      rdq(8'h18, 32'h0000_0001 << i);
      rdq(8'h18, 32'h0000_0000);
    end
    lf = nxt(lf);
    bc = {14'h0000, lf[1:0]} + 16'h0001;
    {ds, po, tw} = lf[5:2];
    ch = 6 + ds + po + tw;
    pulse(7'h00);
    fork
      u_far.hold_low((ch + 3) * bc);
      begin
        repeat (ch * bc) @(negedge clk_sys_in);
        `CHK("early zero load", 0, nz)
      end
    join
    pulse(7'h00);
    `CHK("zero loads", 1, nz)
    rdq(8'h14, 32'h0000_0079);
    rdq(8'h14, 32'h0000_0061);
    pulse(7'h08);
    summarize();
  end
endmodule : test_uart_line_modem_status
